/* inc/srs_regs.svh */
// constants of the two-wire register access slave
`ifndef SRS_REGS_SVH
`define SRS_REGS_SVH

// fixed upper bits of the seven-bit slave address
`define SRS_ADDR_PREFIX 2'h2
// broadcast write address byte, direction bit included
`define SRS_MASS_WR_ADDR 8'hBE
// alert response address byte, direction bit included
`define SRS_ARA_ADDR 8'h19
// mass write enable bit inside the low control byte
`define SRS_CTRL_MASS_WR_BIT 4
// tri-level strap encodings, two sense bits per pin
`define SRS_TRI_L 2'h0
`define SRS_TRI_H 2'h1
`define SRS_TRI_Z 2'h2
// core cycles after reset release before straps are caught
`define SRS_STRAP_SETTLE 4
// bits in one byte on the wire
`define SRS_BYTE_BITS 4'h8
// reset values
`define SRS_PTR_RST 8'h00
`define SRS_ADDR_RST 7'h00

`endif

/* inc/srs_pkg.sv */
// types of the two-wire register access slave
package srs_pkg;

    // byte engine states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_CMD,
        ST_WDATA,
        ST_ACK,
        ST_TX,
        ST_MACK,
        ST_WAIT
    } srs_state_t;

    // sensed level of one tri-level strap pin
    typedef logic [1:0] srs_tri_t;

endpackage : srs_pkg

/* hw/srs_strap_decode.sv */
// strap synchroniser, capture after reset and tri-level address decode
`timescale 1ns/10ps
`default_nettype none
`include "srs_regs.svh"

module srs_strap_decode
    import srs_pkg::*;
#(
    parameter int SETTLE = `SRS_STRAP_SETTLE
) (
    // core clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // straps, pin 2 in bits 5:4, pin 1 in 3:2, pin 0 in 1:0
    input wire logic [5:0] addr_strap_pins,
    // decoded address
    output logic [6:0] own_addr,
    output logic addr_ok
);

    if (SETTLE < 3 || SETTLE > 15) begin : g_bad_settle
        $error("SETTLE must be 3 to 15");
    end

    localparam srs_tri_t L = `SRS_TRI_L;
    localparam srs_tri_t H = `SRS_TRI_H;
    localparam srs_tri_t Z = `SRS_TRI_Z;

    logic [5:0] strap_meta_q;
    logic [5:0] strap_sync_q;
    logic [3:0] settle_cnt_q;
    logic [6:0] own_addr_q;
    logic addr_ok_q;
    wire logic [5:0] strap_norm;

    // pattern to low five address bits; an illegal code reads as open
    function automatic logic [4:0] strap_code(input logic [5:0] p);
        strap_code = 5'h0A;
        case (p)
            {L, Z, L}: strap_code = 5'h00;
            {L, H, Z}: strap_code = 5'h01;
            {L, Z, Z}: strap_code = 5'h02;
            {L, Z, H}: strap_code = 5'h03;
            {L, L, L}: strap_code = 5'h04;
            {L, H, H}: strap_code = 5'h05;
            {L, L, Z}: strap_code = 5'h06;
            {L, L, H}: strap_code = 5'h07;
            {Z, Z, L}: strap_code = 5'h08;
            {Z, H, Z}: strap_code = 5'h09;
            {Z, Z, Z}: strap_code = 5'h0A;
            {Z, Z, H}: strap_code = 5'h0B;
            {Z, L, L}: strap_code = 5'h0C;
            {Z, H, H}: strap_code = 5'h0D;
            {Z, L, Z}: strap_code = 5'h0E;
            {Z, L, H}: strap_code = 5'h0F;
            {H, Z, L}: strap_code = 5'h10;
            {H, H, Z}: strap_code = 5'h11;
            {H, Z, Z}: strap_code = 5'h12;
            {H, Z, H}: strap_code = 5'h13;
            {H, L, L}: strap_code = 5'h14;
            {H, H, H}: strap_code = 5'h15;
            {H, L, Z}: strap_code = 5'h16;
            {H, L, H}: strap_code = 5'h17;
            {L, H, L}: strap_code = 5'h18;
            {Z, H, L}: strap_code = 5'h19;
            {H, H, L}: strap_code = 5'h1A;
            default: strap_code = 5'h0A;
        endcase
    endfunction : strap_code

    // straps are pins, two flops before anything reads them
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            strap_meta_q <= 6'h00;
            strap_sync_q <= 6'h00;
        end else begin
            strap_meta_q <= addr_strap_pins;
            strap_sync_q <= strap_meta_q;
        end
    end

    // an unused code 11 on one pin reads as open for that pin alone
    for (genvar i = 0; i < 3; i++) begin : g_norm
        assign strap_norm[2*i +: 2] = (&strap_sync_q[2*i +: 2]) ? Z : strap_sync_q[2*i +: 2];
    end

    // caught once after release; later strap changes are ignored on purpose
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            settle_cnt_q <= 4'h0;
            own_addr_q <= `SRS_ADDR_RST;
            addr_ok_q <= 1'b0;
        end else if (!addr_ok_q) begin
            if (settle_cnt_q == 4'(SETTLE)) begin
                own_addr_q <= {`SRS_ADDR_PREFIX, strap_code(strap_norm)};
                addr_ok_q <= 1'b1;
            end else begin
                settle_cnt_q <= settle_cnt_q + 4'h1;
            end
        end
    end

    assign own_addr = own_addr_q;
    assign addr_ok = addr_ok_q;

endmodule : srs_strap_decode

`default_nettype wire

/* hw/srs_slave_top.sv */
// two-wire register access slave: byte engine, address match, pointer, alert
`timescale 1ns/10ps
`default_nettype none
`include "srs_regs.svh"

// Functional notes
// - serve byte, word and continuous reads and writes as a bus slave
// - idle bus has both lines high; sda falling with scl high starts
// - sda rising with scl high is a stop; the bus is free afterwards
// - slave address picked from 27 values by three tri-level straps
// - upper two bits of the address byte are fixed at binary 10
// - broadcast write address is accepted as if individually addressed
// - broadcast response off while mass write control bit is zero
// - alert response address acked while alerting; send own address, then release
// - transmitter of a byte releases sda during its acknowledge pulse
// - as receiver, hold sda low through the acknowledge pulse
// - write: address with direction zero, command byte loads the pointer
// - each written byte is acked, stored at the pointer, pointer increments
// - read: pointer loaded, repeated start, direction one, data returned
// - after each master-acked byte the pointer increments, next byte sent
// - result registers frozen from start to stop via the busy level
// - status and fault registers stay live through a transaction
// - alert drives low when an enabled logged fault bit becomes set
// - no new alert for a persisting fault, only a new or recurring one

module srs_slave_top
    import srs_pkg::*;
#(
    parameter int FAULT_W = 8,
    parameter int STRAP_SETTLE = `SRS_STRAP_SETTLE
) (
    // core clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // two-wire link; scl also clocks the link shifter
    input wire logic scl_clk,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // address straps, two sense bits per pin
    input wire logic [5:0] addr_strap_pins,
    // register file side
    output logic [7:0] reg_ptr,
    output logic reg_wr,
    output logic [7:0] reg_wr_addr,
    output logic [7:0] reg_wr_data,
    output logic reg_rd,
    input wire logic [7:0] reg_rd_data,
    output logic xact_busy,
    // configuration and fault state from the register file
    input wire logic [7:0] ctrl_cfg,
    input wire logic [FAULT_W-1:0] fault_log,
    input wire logic [FAULT_W-1:0] alert_en,
    // alert pin, open drain
    output logic alert_out,
    output logic alert_oe
);

    if (FAULT_W < 1 || FAULT_W > 8) begin : g_bad_fault_w
        $error("FAULT_W must be 1 to 8");
    end

    srs_state_t state_q;
    srs_state_t ack_next_q;
    logic [3:0] bit_cnt_q;
    logic ara_q;
    logic [7:0] link_sh_q;
    logic [1:0] scl_sync_q;
    logic [1:0] sda_sync_q;
    logic scl_prev_q;
    logic sda_prev_q;
    logic sda_oe_q;
    logic [7:0] tx_q;
    logic [7:0] ptr_q;
    logic reg_wr_q;
    logic [7:0] reg_wr_addr_q;
    logic [7:0] reg_wr_data_q;
    logic reg_rd_q;
    logic busy_q;
    logic alert_oe_q;
    logic [FAULT_W-1:0] reported_q;
    logic [6:0] own_addr;
    logic addr_ok;

    srs_strap_decode #(
        .SETTLE(STRAP_SETTLE)
    ) u_strap (
        .core_clk(core_clk),
        .rstn(rstn),
        .addr_strap_pins(addr_strap_pins),
        .own_addr(own_addr),
        .addr_ok(addr_ok)
    );

    // link domain: only a free shifter sampling sda on each scl rise
    always_ff @(posedge scl_clk or negedge rstn) begin
        if (!rstn) begin
            link_sh_q <= 8'h00;
        end else begin
            link_sh_q <= {link_sh_q[6:0], sda_in};
        end
    end

    // both pins into the core domain; reset to the idle-high level
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            scl_sync_q <= 2'h3;
            sda_sync_q <= 2'h3;
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else begin
            scl_sync_q <= {scl_sync_q[0], scl_clk};
            sda_sync_q <= {sda_sync_q[0], sda_in};
            scl_prev_q <= scl_sync_q[1];
            sda_prev_q <= sda_sync_q[1];
        end
    end

    // line events seen in the core domain
    logic scl_s;
    logic sda_s;
    logic start_ev;
    logic stop_ev;
    logic scl_rise;
    logic scl_fall;
    assign scl_s = scl_sync_q[1];
    assign sda_s = sda_sync_q[1];
    assign start_ev = scl_s && scl_prev_q && sda_prev_q && !sda_s;
    assign stop_ev = scl_s && scl_prev_q && !sda_prev_q && sda_s;
    assign scl_rise = scl_s && !scl_prev_q;
    assign scl_fall = !scl_s && scl_prev_q;

    // the shifter only moves on scl rises, so it is steady at the fall after bit 8
    logic byte_end;
    assign byte_end = scl_fall && (bit_cnt_q == `SRS_BYTE_BITS);

    // address matching on the byte just received
    logic own_hit;
    logic own_rd;
    logic mass_hit;
    logic ara_hit;
    logic addr_hit;
    assign own_hit = addr_ok && (link_sh_q[7:1] == own_addr);
    assign own_rd = link_sh_q[0];
    assign mass_hit = ctrl_cfg[`SRS_CTRL_MASS_WR_BIT] && (link_sh_q == `SRS_MASS_WR_ADDR);
    assign ara_hit = alert_oe_q && (link_sh_q == `SRS_ARA_ADDR);
    assign addr_hit = own_hit || mass_hit || ara_hit;

    // byte to send: own address for an alert response, else the register
    logic [7:0] tx_src;
    assign tx_src = ara_q ? {own_addr, 1'b0} : reg_rd_data;

    // alert release point: own address fully shifted out
    logic ara_done;
    assign ara_done = (state_q == ST_TX) && byte_end && ara_q;

    // byte engine sequencing; start and stop override everything
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= ST_IDLE;
            ack_next_q <= ST_IDLE;
            bit_cnt_q <= 4'h0;
            ara_q <= 1'b0;
        end else if (stop_ev) begin
            state_q <= ST_IDLE;
            bit_cnt_q <= 4'h0;
            ara_q <= 1'b0;
        end else if (start_ev) begin
            state_q <= ST_ADDR;
            bit_cnt_q <= 4'h0;
            ara_q <= 1'b0;
        end else begin
            if (scl_rise && (bit_cnt_q != `SRS_BYTE_BITS) &&
                    (state_q inside {ST_ADDR, ST_CMD, ST_WDATA, ST_TX})) begin
                bit_cnt_q <= bit_cnt_q + 4'h1;
            end
            case (state_q)
                ST_ADDR: begin
                    if (byte_end) begin
                        bit_cnt_q <= 4'h0;
                        if (ara_hit) begin
                            state_q <= ST_ACK;
                            ack_next_q <= ST_TX;
                            ara_q <= 1'b1;
                        end else if (own_hit) begin
                            state_q <= ST_ACK;
                            ack_next_q <= own_rd ? ST_TX : ST_CMD;
                        end else if (mass_hit) begin
                            state_q <= ST_ACK;
                            ack_next_q <= ST_CMD;
                        end else begin
                            state_q <= ST_WAIT;
                        end
                    end
                end
                ST_CMD, ST_WDATA: begin
                    if (byte_end) begin
                        bit_cnt_q <= 4'h0;
                        state_q <= ST_ACK;
                        ack_next_q <= ST_WDATA;
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        state_q <= ack_next_q;
                    end
                end
                ST_TX: begin
                    if (byte_end) begin
                        bit_cnt_q <= 4'h0;
                        state_q <= ST_MACK;
                    end
                end
                ST_MACK: begin
                    // a nack, or any answer to the alert response, ends our part
                    if (scl_rise) begin
                        if (sda_s || ara_q) begin
                            state_q <= ST_WAIT;
                        end else begin
                            state_q <= ST_ACK;
                            ack_next_q <= ST_TX;
                        end
                    end
                end
                default: begin
                    state_q <= state_q;
                end
            endcase
        end
    end

    // sda drive: pulled only on a seen scl fall, so never while scl is high; start and stop release it
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            sda_oe_q <= 1'b0;
            tx_q <= 8'h00;
        end else if (start_ev || stop_ev) begin
            sda_oe_q <= 1'b0;
        end else if (scl_fall) begin
            case (state_q)
                ST_ADDR: begin
                    if (bit_cnt_q == `SRS_BYTE_BITS) begin
                        sda_oe_q <= addr_hit;
                    end
                end
                ST_CMD, ST_WDATA: begin
                    if (bit_cnt_q == `SRS_BYTE_BITS) begin
                        sda_oe_q <= 1'b1;
                    end
                end
                ST_ACK: begin
                    if (ack_next_q == ST_TX) begin
                        sda_oe_q <= ~tx_src[7];
                        tx_q <= {tx_src[6:0], 1'b0};
                    end else begin
                        sda_oe_q <= 1'b0;
                    end
                end
                ST_TX: begin
                    if (bit_cnt_q == `SRS_BYTE_BITS) begin
                        sda_oe_q <= 1'b0;
                    end else begin
                        sda_oe_q <= ~tx_q[7];
                        tx_q <= {tx_q[6:0], 1'b0};
                    end
                end
                default: begin
                    sda_oe_q <= 1'b0;
                end
            endcase
        end
    end

    // register pointer, write strobe and read strobe
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            ptr_q <= `SRS_PTR_RST;
            reg_wr_q <= 1'b0;
            reg_wr_addr_q <= `SRS_PTR_RST;
            reg_wr_data_q <= 8'h00;
            reg_rd_q <= 1'b0;
        end else begin
            reg_wr_q <= 1'b0;
            reg_rd_q <= 1'b0;
            if ((state_q == ST_CMD) && byte_end) begin
                ptr_q <= link_sh_q;
            end else if ((state_q == ST_WDATA) && byte_end) begin
                reg_wr_q <= 1'b1;
                reg_wr_addr_q <= ptr_q;
                reg_wr_data_q <= link_sh_q;
                ptr_q <= ptr_q + 8'h01;
            end else if ((state_q == ST_MACK) && scl_rise && !sda_s && !ara_q) begin
                ptr_q <= ptr_q + 8'h01;
            end
            if ((state_q == ST_ACK) && scl_fall && (ack_next_q == ST_TX) && !ara_q) begin
                reg_rd_q <= 1'b1;
            end
        end
    end

    // transaction busy freezes result registers outside; status stays live
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            busy_q <= 1'b0;
        end else if (stop_ev) begin
            busy_q <= 1'b0;
        end else if (start_ev) begin
            busy_q <= 1'b1;
        end
    end

    // alert: a bit once reported stays quiet until its log bit clears
    logic [FAULT_W-1:0] pend;
    logic [FAULT_W-1:0] fresh;
    assign pend = fault_log & alert_en;
    assign fresh = pend & ~reported_q;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            reported_q <= '0;
            alert_oe_q <= 1'b0;
        end else begin
            reported_q <= (reported_q & fault_log) | pend;
            if (|fresh) begin
                alert_oe_q <= 1'b1;
            end else if (ara_done) begin
                alert_oe_q <= 1'b0;
            end
        end
    end

    // both pins only ever pull low
    assign sda_out = 1'b0;
    assign sda_oe = sda_oe_q;
    assign alert_out = 1'b0;
    assign alert_oe = alert_oe_q;
    assign reg_ptr = ptr_q;
    assign reg_wr = reg_wr_q;
    assign reg_wr_addr = reg_wr_addr_q;
    assign reg_wr_data = reg_wr_data_q;
    assign reg_rd = reg_rd_q;
    assign xact_busy = busy_q;

endmodule : srs_slave_top

`default_nettype wire

/* testbench/srs_slave_checker.sv */
// assertion checker for the two-wire register access slave
`timescale 1ns/10ps
`default_nettype none
module srs_slave_checker
    import srs_pkg::*;
#(
    parameter int FAULT_W = 8
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // link
    input wire logic scl_clk,
    input wire logic sda_oe,
    // register file side
    input wire logic [7:0] reg_ptr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wr_addr,
    input wire logic reg_rd,
    input wire logic xact_busy,
    // alert
    input wire logic [FAULT_W-1:0] fault_log,
    input wire logic [FAULT_W-1:0] alert_en,
    input wire logic alert_oe
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    // strobes are single cycles and only inside a transaction
    property p_wr_pulse;
        reg_wr |-> xact_busy ##1 !reg_wr;
    endproperty
    a_wr_pulse: assert property (p_wr_pulse) else $error("bad write strobe");
    property p_wr_ptr;
        reg_wr |-> ##[0:2] (reg_ptr == reg_wr_addr + 8'h01);
    endproperty
    a_wr_ptr: assert property (p_wr_ptr) else $error("pointer missed step");
    property p_rd_pulse;
        reg_rd |-> xact_busy ##1 !reg_rd;
    endproperty
    a_rd_pulse: assert property (p_rd_pulse) else $error("bad read strobe");
    // pointer only moves while the bus is busy
    property p_ptr_hold;
        !xact_busy && !$past(xact_busy) |-> $stable(reg_ptr);
    endproperty
    a_ptr_hold: assert property (p_ptr_hold) else $error("pointer moved idle");
    property p_sda_free;
        !xact_busy && !$past(xact_busy) |-> !sda_oe;
    endproperty
    a_sda_free: assert property (p_sda_free) else $error("sda held on free bus");
    // a pull may only start while scl is low, and is held for 8 core cycles after an scl rise
    property p_sda_rise;
        $rose(sda_oe) |-> !scl_clk;
    endproperty
    a_sda_rise: assert property (p_sda_rise) else $error("sda pulled with scl high");
    property p_ack_hold;
        $rose(scl_clk) && sda_oe |=> sda_oe [*8];
    endproperty
    a_ack_hold: assert property (p_ack_hold) else $error("sda let go early");
    // a fresh enabled fault pulls alert on the next edge
    property p_alert_new;
        |(fault_log & alert_en & ~($past(fault_log) & $past(alert_en))) |=> alert_oe;
    endproperty
    a_alert_new: assert property (p_alert_new) else $error("alert not raised");
    property p_alert_cause;
        $rose(alert_oe) |-> |($past(fault_log) & $past(alert_en));
    endproperty
    a_alert_cause: assert property (p_alert_cause) else $error("alert without fault");
    // release only happens inside an alert response transfer
    property p_alert_keep;
        alert_oe && !xact_busy |=> alert_oe;
    endproperty
    a_alert_keep: assert property (p_alert_keep) else $error("alert dropped idle");
endmodule : srs_slave_checker

bind srs_slave_top srs_slave_checker #(.FAULT_W(FAULT_W)) u_chk (
    .core_clk(core_clk), .rstn(rstn), .scl_clk(scl_clk), .sda_oe(sda_oe),
    .reg_ptr(reg_ptr), .reg_wr(reg_wr), .reg_wr_addr(reg_wr_addr), .reg_rd(reg_rd),
    .xact_busy(xact_busy), .fault_log(fault_log), .alert_en(alert_en), .alert_oe(alert_oe)
);
`default_nettype wire

/* testbench/srs_master_model.sv */
// behavioural two-wire bus master driving scl and pulling sda
`timescale 1ns/10ps
`default_nettype none
module srs_master_model (
    // bus wires; scl idles high between frames
    output logic scl,
    output logic sda_pull,
    input wire logic sda_line
);
    localparam realtime Q = 31.25;
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    // start or repeated start: sda falls with scl high
    task automatic bus_start();
        sda_pull = 1'b0;
        #Q scl = 1'b1;
        #Q sda_pull = 1'b1;
        #Q scl = 1'b0;
        #Q;
    endtask : bus_start
    // stop: sda rises with scl high, clock then stands still
    task automatic bus_stop();
        sda_pull = 1'b1;
        #Q scl = 1'b1;
        #Q sda_pull = 1'b0;
        #Q;
    endtask : bus_stop
    // data set a quarter period after the fall, sampled mid high
    task automatic bus_bit(input logic b, output logic r);
        sda_pull = !b;
        #Q scl = 1'b1;
        #Q r = sda_line;
        #Q scl = 1'b0;
        #Q;
    endtask : bus_bit
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bus_bit(d[i], r);
        bus_bit(1'b1, r);
        ack = !r;
    endtask : wr_byte
    // master acks all but the final byte of a read
    task automatic rd_byte(input logic mack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bus_bit(1'b1, r);
            d[i] = r;
        end
        bus_bit(!mack, r);
    endtask : rd_byte
endmodule : srs_master_model
`default_nettype wire

/* testbench/tb_top.sv */
// self-checking bench for the two-wire register access slave
`timescale 1ns/10ps
`default_nettype none
module tb_top
    import srs_pkg::*;
;
    typedef struct packed {
        logic [5:0] strap;
        logic [7:0] cfg;
        logic [7:0] addr;
        logic ack;
    } srs_row_t;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic [5:0] addr_strap_pins = 6'h00;
    logic [7:0] ctrl_cfg = 8'h10;
    logic [7:0] fault_log = 8'h00;
    logic [7:0] alert_en = 8'h00;
    wire logic scl;
    wire logic m_pull;
    wire logic sda_line;
    wire logic [7:0] reg_rd_data;
    logic sda_out, sda_oe, reg_wr, reg_rd, xact_busy, alert_out, alert_oe;
    logic [7:0] reg_ptr, reg_wr_addr, reg_wr_data, d;
    logic [15:0] wq[$];
    logic ack;
    int fails = 0;
    int samples_checked = 0;
    // straps: pin2 5:4, pin1 3:2, pin0 1:0; 0 low, 1 high, 2 or 3 open
    srs_row_t rows [10] = '{
        '{6'h19, 8'h10, 8'hA6, 1'b1}, '{6'h08, 8'h10, 8'h80, 1'b1},
        '{6'h2A, 8'h10, 8'h94, 1'b1}, '{6'h14, 8'h10, 8'hB4, 1'b1},
        '{6'h37, 8'h10, 8'h92, 1'b1}, '{6'h19, 8'h10, 8'hA8, 1'b0},
        '{6'h19, 8'h10, 8'hBE, 1'b1}, '{6'h19, 8'h00, 8'hBE, 1'b0},
        '{6'h19, 8'h10, 8'h19, 1'b0}, '{6'h19, 8'h10, 8'hBF, 1'b0}};

    always #2 core_clk = ~core_clk;
    // open-drain wire with pull-up; register file returns the pointer xor 5A
    assign sda_line = (sda_oe ? sda_out : 1'b1) && !m_pull;
    assign reg_rd_data = reg_ptr ^ 8'h5A;
    always @(posedge core_clk) if (reg_wr === 1'b1) wq.push_back({reg_wr_addr, reg_wr_data});

    srs_slave_top #(.FAULT_W(8), .STRAP_SETTLE(4)) dut_u (
        .core_clk(core_clk), .rstn(rstn), .scl_clk(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe(sda_oe), .addr_strap_pins(addr_strap_pins),
        .reg_ptr(reg_ptr), .reg_wr(reg_wr), .reg_wr_addr(reg_wr_addr),
        .reg_wr_data(reg_wr_data), .reg_rd(reg_rd), .reg_rd_data(reg_rd_data),
        .xact_busy(xact_busy), .ctrl_cfg(ctrl_cfg), .fault_log(fault_log),
        .alert_en(alert_en), .alert_out(alert_out), .alert_oe(alert_oe));
    srs_master_model u_mst (.scl(scl), .sda_pull(m_pull), .sda_line(sda_line));

    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            $display("MISMATCH %s expected %h seen %h", n, e, g);
            fails++;
        end
    endtask : chk
    task automatic stop_test();
        $display("compares %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : stop_test
    // straps are only caught after reset, so each strap needs a fresh reset
    task automatic do_reset(input logic [5:0] s, input logic [7:0] c);
        @(posedge core_clk);
        #1 rstn = 1'b0;
        addr_strap_pins = s;
        ctrl_cfg = c;
        repeat (4) @(posedge core_clk);
        chk("rst_out", 8'h00, {1'b0, reg_rd, sda_out, alert_out, sda_oe, alert_oe, reg_wr, xact_busy});
        chk("rst_ptr", 8'h00, reg_ptr);
        #1 rstn = 1'b1;
        repeat (12) @(posedge core_clk);
    endtask : do_reset
    task automatic set_fault(input logic [7:0] f, input logic [7:0] e);
        @(posedge core_clk);
        #1 fault_log = f;
        alert_en = e;
        repeat (3) @(posedge core_clk);
    endtask : set_fault
    // alert response: ack 0x19, own address back, master nack, alert released
    task automatic ara();
        u_mst.bus_start();
        u_mst.wr_byte(8'h19, ack);
        chk("ara_ack", 8'h01, {7'h00, ack});
        u_mst.rd_byte(1'b0, d);
        chk("ara_addr", 8'hA6, d);
        u_mst.bus_stop();
        repeat (4) @(posedge core_clk);
        chk("ara_rel", 8'h00, {7'h00, alert_oe});
    endtask : ara

    initial begin
        #200000;
        fails++;
        stop_test();
    end
    initial begin
        foreach (rows[i]) begin
            do_reset(rows[i].strap, rows[i].cfg);
            u_mst.bus_start();
            u_mst.wr_byte(rows[i].addr, ack);
            chk("addr_ack", {7'h00, rows[i].ack}, {7'h00, ack});
            u_mst.bus_stop();
        end
        // continuous write across the pointer wrap
        do_reset(6'h19, 8'h10);
        wq.delete();
        u_mst.bus_start();
        u_mst.wr_byte(8'hA6, ack);
        u_mst.wr_byte(8'hFE, ack);
        chk("cmd_ack", 8'h01, {7'h00, ack});
        chk("busy", 8'h01, {7'h00, xact_busy});
        for (int i = 0; i < 3; i++) begin
            u_mst.wr_byte(8'hC0 + i[7:0], ack);
            chk("data_ack", 8'h01, {7'h00, ack});
        end
        u_mst.bus_stop();
        repeat (4) @(posedge core_clk);
        chk("busy_end", 8'h00, {7'h00, xact_busy});
        chk("wr_count", 8'h03, 8'(wq.size()));
        for (int i = 0; i < 3; i++) begin
            if (i < wq.size()) chk("wr_addr", 8'hFE + i[7:0], wq[i][15:8]);
            if (i < wq.size()) chk("wr_data", 8'hC0 + i[7:0], wq[i][7:0]);
        end
        chk("ptr_wr", 8'h01, reg_ptr);
        // pointer load, repeated start, three bytes read
        u_mst.bus_start();
        u_mst.wr_byte(8'hA6, ack);
        u_mst.wr_byte(8'h40, ack);
        u_mst.bus_start();
        u_mst.wr_byte(8'hA7, ack);
        chk("rd_ack", 8'h01, {7'h00, ack});
        for (int i = 0; i < 3; i++) begin
            u_mst.rd_byte(i < 2, d);
            chk("rd_data", (8'h40 + i[7:0]) ^ 8'h5A, d);
        end
        u_mst.bus_stop();
        repeat (4) @(posedge core_clk);
        chk("ptr_rd", 8'h42, reg_ptr);
        // alert raise, release, persist, new bit, recurrence, masking
        set_fault(8'h01, 8'h01);
        chk("alert_on", 8'h01, {7'h00, alert_oe});
        ara();
        set_fault(8'h01, 8'h01);
        chk("alert_persist", 8'h00, {7'h00, alert_oe});
        set_fault(8'h03, 8'h03);
        chk("alert_new", 8'h01, {7'h00, alert_oe});
        ara();
        set_fault(8'h02, 8'h03);
        set_fault(8'h03, 8'h03);
        chk("alert_again", 8'h01, {7'h00, alert_oe});
        ara();
        set_fault(8'h07, 8'h03);
        chk("alert_mask", 8'h00, {7'h00, alert_oe});
        set_fault(8'h07, 8'h07);
        chk("alert_enable", 8'h01, {7'h00, alert_oe});
        ara();
        stop_test();
    end
endmodule : tb_top
`default_nettype wire
